// ===== rtl/icu_core.sv
// top of the interrupt unit: registers, pending flags, routing and nmi merge
// assumes all inputs synchronous to core_clk_in and a master that never waits
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "icu_regs.svh"
module icu_core import icu_pkg::*; #(
  parameter int             N_SRC     = 256,
  parameter logic [255:0]   EDGE_MASK = {256{1'b1}}
) (
  input  wire logic               core_clk_in,
  input  wire logic               sys_rst_in,
  input  wire logic [9:0]         reg_addr_in,
  input  wire logic [31:0]        reg_wdata_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  output logic      [31:0]        reg_rdata_out,
  input  wire logic [N_SRC-1:0]   periph_req_in,
  input  wire logic               cpu_ack_in,
  input  wire logic [7:0]         cpu_ack_vec_in,
  input  wire logic [N_SRC-1:0]   xfer_ack_in,
  output logic                    cpu_irq_out,
  output logic      [7:0]         cpu_vec_out,
  output logic      [3:0]         cpu_level_out,
  output logic                    cpu_fast_irq_out,
  output logic      [7:0]         cpu_fast_vec_out,
  output logic      [N_SRC-1:0]   data_transfer_controller_req_out,
  output logic      [N_SRC-1:0]   dma_controller_req_out,
  output logic                    external_bus_dma_ch0_start_out,
  output logic                    external_bus_dma_ch1_start_out,
  input  wire logic               nmi_pin_in,
  input  wire logic               osc_stop_in,
  input  wire logic               system_watchdog_err_in,
  input  wire logic               independent_watchdog_err_in,
  input  wire logic               voltage_detector_one_in,
  input  wire logic               voltage_detector_two_in,
  input  wire logic               ram_parity_err_in,
  output logic                    nmi_irq_out
);
  if (N_SRC != 256) begin : g_bad_size
    $error("icu_core serves exactly 256 sources");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic [6:0]       src_cfg [N_SRC];
  logic [N_SRC-1:0] pend;
  logic [N_SRC-1:0] req_d;
  logic [8:0]       fast_sel;
  logic [6:0]       nmi_stat;
  logic [6:0]       nmi_en;
  logic [3:0]       nmi_ctrl;
  logic [1:0]       exdma_en;
  logic [5:0]       div_cnt;

  icu_arb_if #(.N_SRC(N_SRC)) arb_bus ();

  ////////////////////////////////////////////////////////////////////////////////
  // address decode
  // the config window is recognised by its top two address bits alone,
  // so the low eight bits are free to carry the source index
  localparam logic [9:0] CFG_BASE = `ICU_OFS_SRC_CFG;
  wire is_cfg   = (reg_addr_in[9:8] == CFG_BASE[9:8]);
  wire is_swint = (reg_addr_in == `ICU_OFS_SWINT_TRIG);
  wire is_fast  = (reg_addr_in == `ICU_OFS_FAST_SEL);
  wire is_nstat = (reg_addr_in == `ICU_OFS_NMI_STAT);
  wire is_nen   = (reg_addr_in == `ICU_OFS_NMI_EN);
  wire is_nctl  = (reg_addr_in == `ICU_OFS_NMI_CTRL);
  wire is_exdma = (reg_addr_in == `ICU_OFS_EXDMA_CTRL);
  wire [7:0] cfg_idx = reg_addr_in[7:0];

  // software triggers are write-only; the pending bit shows the effect
  wire [1:0] sw_set = (reg_wr_in && is_swint) ? reg_wdata_in[1:0] : 2'b00;

  wire [7:0] fast_idx = fast_sel[7:0];
  wire       fast_en  = fast_sel[`ICU_FAST_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // per-source detection and routing
  logic [N_SRC-1:0] set_vec;
  logic [N_SRC-1:0] clr_vec;
  logic [N_SRC-1:0] cpu_cand;
  logic [N_SRC-1:0] next_dtc_req;
  logic [N_SRC-1:0] next_dma_req;

  for (genvar i = 0; i < N_SRC; i++) begin : g_src
    wire is_sw0  = (8'(i) == `ICU_SWINT0_IDX);
    wire is_sw1  = (8'(i) == `ICU_SWINT1_IDX);
    wire ack_hit = cpu_ack_in && (cpu_ack_vec_in == 8'(i));
    wire to_xfer = src_cfg[i][`ICU_CFG_XFER_BIT];
    wire to_dma  = src_cfg[i][`ICU_CFG_DMA_BIT];
    wire to_cpu  = src_cfg[i][`ICU_CFG_CPU_BIT];
    // detection kind is a build parameter, no register can change it
    assign set_vec[i] = is_sw0 ? sw_set[0] :
                        is_sw1 ? sw_set[1] :
                        EDGE_MASK[i] ? (periph_req_in[i] & ~req_d[i])
                                     : periph_req_in[i];
    // level sources simply follow the input; edge sources wait for an answer
    assign clr_vec[i] = (EDGE_MASK[i] || is_sw0 || is_sw1) ? (ack_hit | xfer_ack_in[i])
                                                             : ~periph_req_in[i];
    assign cpu_cand[i] = pend[i] && to_cpu && !(fast_en && fast_idx == 8'(i));
    assign next_dtc_req[i] = pend[i] && to_xfer && !to_dma;
    assign next_dma_req[i] = pend[i] && to_xfer && to_dma;
    assign arb_bus.req[i] = cpu_cand[i];
    assign arb_bus.lvl[i] = src_cfg[i][`ICU_CFG_LVL_MSB:0];
  end

  icu_prio_arb #(.N_SRC(N_SRC)) u_arb (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .arb         (arb_bus.arb)
  );

  // external dma starts follow a fresh request on either fixed source of the enabled channel
  wire exdma0_hit = exdma_en[0] &&
                    (set_vec[`ICU_EXDMA0_B_IDX] || set_vec[`ICU_EXDMA0_A_IDX]);
  wire exdma1_hit = exdma_en[1] &&
                    (set_vec[`ICU_EXDMA1_B_IDX] || set_vec[`ICU_EXDMA1_A_IDX]);
  wire fast_hit   = fast_en && pend[fast_idx] && src_cfg[fast_idx][`ICU_CFG_CPU_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // pending flags, configuration store and cpu outputs
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pend  <= '0;
      req_d <= '0;
      for (int i = 0; i < N_SRC; i++) begin
        src_cfg[i] <= `ICU_CFG_RST;
      end
    end else begin
      pend  <= set_vec | (pend & ~clr_vec);
      req_d <= periph_req_in;
      if (reg_wr_in && is_cfg) begin
        src_cfg[cfg_idx] <= reg_wdata_in[6:0];
      end
    end
  end

  // outputs are registered so the cpu sees a clean vector and level together
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cpu_irq_out      <= 1'b0;
      cpu_vec_out      <= 8'h00;
      cpu_level_out    <= 4'h0;
      cpu_fast_irq_out <= 1'b0;
      cpu_fast_vec_out <= 8'h00;
      data_transfer_controller_req_out <= '0;
      dma_controller_req_out           <= '0;
      external_bus_dma_ch0_start_out   <= 1'b0;
      external_bus_dma_ch1_start_out   <= 1'b0;
    end else begin
      cpu_irq_out      <= arb_bus.win_valid;
      cpu_vec_out      <= arb_bus.win_idx;
      cpu_level_out    <= arb_bus.win_lvl;
      cpu_fast_irq_out <= fast_hit;
      cpu_fast_vec_out <= fast_idx;
      data_transfer_controller_req_out <= next_dtc_req;
      dma_controller_req_out           <= next_dma_req;
      external_bus_dma_ch0_start_out   <= exdma0_hit;
      external_bus_dma_ch1_start_out   <= exdma1_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // non-maskable sources
  logic       pin_edge;
  logic       sample_en;
  logic [5:0] div_lim;

  // sample divider: slower sampling rejects longer glitches at the cost of latency
  always_comb begin
    unique case (nmi_ctrl[`ICU_NMI_DIV_LSB +: 2])
      2'h0: div_lim = `ICU_DIV1_LIM;
      2'h1: div_lim = `ICU_DIV8_LIM;
      2'h2: div_lim = `ICU_DIV32_LIM;
      2'h3: div_lim = `ICU_DIV64_LIM;
    endcase
  end
  assign sample_en = (div_cnt >= div_lim);

  icu_nmi_filter u_nmi_filt (
    .core_clk_in  (core_clk_in),
    .sys_rst_in   (sys_rst_in),
    .pin_in       (nmi_pin_in),
    .filt_en_in   (nmi_ctrl[`ICU_NMI_FILT_BIT]),
    .sample_en_in (sample_en),
    .rise_sel_in  (nmi_ctrl[`ICU_NMI_RISE_BIT]),
    .edge_out     (pin_edge)
  );

  wire [6:0] nmi_evt = {ram_parity_err_in,
                        voltage_detector_two_in,
                        voltage_detector_one_in,
                        independent_watchdog_err_in,
                        system_watchdog_err_in,
                        osc_stop_in,
                        pin_edge};
  wire [6:0] nmi_clr = (reg_wr_in && is_nstat) ? reg_wdata_in[6:0] : 7'h00;

  // a new event in the clearing cycle wins over the one-to-clear
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      nmi_stat <= 7'h00;
      div_cnt  <= 6'h00;
    end else begin
      nmi_stat <= nmi_evt | (nmi_stat & ~nmi_clr);
      div_cnt  <= sample_en ? 6'h00 : div_cnt + 6'h01;
    end
  end

  assign nmi_irq_out = |(nmi_stat & nmi_en);

  ////////////////////////////////////////////////////////////////////////////////
  // control registers and read port
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      fast_sel <= `ICU_FAST_RST;
      nmi_en   <= `ICU_NMI_EN_RST;
      nmi_ctrl <= `ICU_NMI_CTRL_RST;
      exdma_en <= 2'b00;
    end else if (reg_wr_in) begin
      if (is_fast) fast_sel <= reg_wdata_in[8:0];
      if (is_nen)  nmi_en   <= reg_wdata_in[6:0];
      if (is_nctl) nmi_ctrl <= reg_wdata_in[3:0];
      if (is_exdma) exdma_en <= reg_wdata_in[1:0];
    end
  end

  wire [31:0] rd_mux = is_cfg   ? {24'h000000, pend[cfg_idx], src_cfg[cfg_idx]} :
                       is_fast  ? {23'h0, fast_sel} :
                       is_nstat ? {25'h0, nmi_stat} :
                       is_nen   ? {25'h0, nmi_en} :
                       is_nctl  ? {28'h0000000, nmi_ctrl} :
                       is_exdma ? {30'h0, exdma_en} : 32'h00000000;

  // read data stands for exactly one cycle after the strobe
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h00000000;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  chk_swint_pending: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (reg_wr_in && is_swint && reg_wdata_in[0]) |=> pend[`ICU_SWINT0_IDX])
    else $error("software trigger did not set its pending flag");

  chk_fast_excluded: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    cpu_irq_out |-> !($past(fast_en) && cpu_vec_out == $past(fast_idx)))
    else $error("fast source also went through normal arbitration");

  chk_level_nonzero: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    cpu_irq_out |-> (cpu_level_out != 4'h0) && $past(pend[arb_bus.win_idx]))
    else $error("cpu request at level zero or without pending source");

  chk_dma_route: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    ((dma_controller_req_out & ~$past(pend)) == '0) &&
      ((dma_controller_req_out & data_transfer_controller_req_out) == '0))
    else $error("dma start without pending source or sent to both controllers");

  chk_exdma0_cause: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    external_bus_dma_ch0_start_out |->
      $past(set_vec[`ICU_EXDMA0_B_IDX] || set_vec[`ICU_EXDMA0_A_IDX]))
    else $error("external dma 0 started without its source");

  chk_exdma1_cause: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    external_bus_dma_ch1_start_out |->
      $past(set_vec[`ICU_EXDMA1_B_IDX] || set_vec[`ICU_EXDMA1_A_IDX]))
    else $error("external dma 1 started without its source");

  chk_osc_stop_nmi: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (osc_stop_in && nmi_en[ICU_NMI_OSC] && !(reg_wr_in && is_nen)) |=> nmi_irq_out)
    else $error("oscillator stop did not raise the nmi");

  chk_vdet_nmi: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    voltage_detector_one_in |=> nmi_stat[ICU_NMI_VDET1])
    else $error("voltage detector one flag not set");

  chk_nmi_sticky: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    ($past(nmi_stat & ~nmi_clr) & ~nmi_stat) == 7'h00)
    else $error("nmi flag dropped without a software clear");
endmodule
`default_nettype wire

// ===== rtl/icu_regs.svh
// register offsets, field positions, reset values and timing counts of the interrupt unit
// assumes a 10-bit word address on the plain register port
`ifndef ICU_REGS_SVH
`define ICU_REGS_SVH
// per-source configuration words occupy 0x000..0x0FF, index = source number
`define ICU_OFS_SRC_CFG    10'h000
`define ICU_OFS_SWINT_TRIG 10'h100
`define ICU_OFS_FAST_SEL   10'h101
`define ICU_OFS_NMI_STAT   10'h102
`define ICU_OFS_NMI_EN     10'h103
`define ICU_OFS_NMI_CTRL   10'h104
`define ICU_OFS_EXDMA_CTRL 10'h105
// source configuration fields
`define ICU_CFG_LVL_MSB    3
`define ICU_CFG_XFER_BIT   4
`define ICU_CFG_DMA_BIT    5
`define ICU_CFG_CPU_BIT    6
`define ICU_CFG_PEND_BIT   7
`define ICU_CFG_RST        7'h40
// fast path select fields
`define ICU_FAST_EN_BIT    8
`define ICU_FAST_RST       9'h000
// nmi control fields
`define ICU_NMI_RISE_BIT   0
`define ICU_NMI_FILT_BIT   1
`define ICU_NMI_DIV_LSB    2
`define ICU_NMI_CTRL_RST   4'h0
`define ICU_NMI_EN_RST     7'h00
`define ICU_NMI_PIN_RST    1'b1
// filter sample dividers in core clocks, minus one
`define ICU_DIV1_LIM       6'h00
`define ICU_DIV8_LIM       6'h07
`define ICU_DIV32_LIM      6'h1F
`define ICU_DIV64_LIM      6'h3F
// fixed source numbers
`define ICU_SWINT0_IDX     8'h1B
`define ICU_SWINT1_IDX     8'h1C
`define ICU_EXDMA0_B_IDX   8'h90
`define ICU_EXDMA0_A_IDX   8'hD0
`define ICU_EXDMA1_B_IDX   8'h91
`define ICU_EXDMA1_A_IDX   8'hD1
`endif

// ===== rtl/icu_pkg.sv
// types shared by the interrupt unit modules
// assumes nothing beyond the compile order
package icu_pkg;
  typedef logic [3:0] icu_level_t;
  typedef logic [7:0] icu_index_t;
  // bit positions of the non-maskable status and enable registers
  typedef enum logic [2:0] {
    ICU_NMI_PIN, ICU_NMI_OSC, ICU_NMI_SYSWD, ICU_NMI_INDWD,
    ICU_NMI_VDET1, ICU_NMI_VDET2, ICU_NMI_RAM
  } icu_nmi_src_t;
  localparam int ICU_NMI_N = 7;
endpackage

// ===== rtl/icu_arb_if.sv
// request and winner bundle between the unit core and its priority arbiter
// assumes both ends sit on the same clock
`timescale 1ns/100ps
`default_nettype none
interface icu_arb_if #(parameter int N_SRC = 256);
  logic [N_SRC-1:0]  req;
  icu_pkg::icu_level_t lvl [N_SRC];
  logic              win_valid;
  icu_pkg::icu_index_t win_idx;
  icu_pkg::icu_level_t win_lvl;
  modport arb  (input req, lvl, output win_valid, win_idx, win_lvl);
  modport core (output req, lvl, input win_valid, win_idx, win_lvl);
endinterface
`default_nettype wire

// ===== rtl/icu_prio_arb.sv
// combinational priority pick among the cpu-bound requests
// assumes the core registers the winner before it leaves the block
`timescale 1ns/100ps
`default_nettype none
module icu_prio_arb import icu_pkg::*; #(
  parameter int N_SRC = 256
) (
  input  wire logic core_clk_in,
  input  wire logic sys_rst_in,
  icu_arb_if.arb    arb
);
  icu_level_t best_lvl;
  icu_index_t best_idx;

  // the winner index is eight bits wide, so more sources cannot be named
  if (N_SRC < 1 || N_SRC > 256) begin : g_bad_size
    $error("icu_prio_arb serves 1 to 256 sources");
  end

  // highest level wins, lower index on a tie; level zero never wins
  always_comb begin
    best_lvl = 4'h0;
    best_idx = 8'h00;
    for (int i = 0; i < N_SRC; i++) begin
      if (arb.req[i] && (arb.lvl[i] > best_lvl)) begin
        best_lvl = arb.lvl[i];
        best_idx = 8'(i);
      end
    end
  end

  assign arb.win_valid = (best_lvl != 4'h0);
  assign arb.win_idx   = best_idx;
  assign arb.win_lvl   = best_lvl;

  chk_arb_winner_live: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    arb.win_valid |-> (arb.req[arb.win_idx] && arb.lvl[arb.win_idx] == arb.win_lvl))
    else $error("arbiter winner is not a live request");
endmodule
`default_nettype wire

// ===== rtl/icu_nmi_filter.sv
// noise filter and edge detector for the non-maskable pin
// assumes the pin is synchronous to core_clk_in and sample_en is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
`include "icu_regs.svh"
module icu_nmi_filter (
  input  wire logic core_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic pin_in,
  input  wire logic filt_en_in,
  input  wire logic sample_en_in,
  input  wire logic rise_sel_in,
  output logic      edge_out
);
  logic [2:0] samples;
  logic       level;
  logic       level_d;
  logic       next_level;

  // three equal samples are needed, so a glitch no longer than two sample periods is lost
  assign next_level = !filt_en_in ? pin_in :
                      (samples == 3'b111) ? 1'b1 :
                      (samples == 3'b000) ? 1'b0 : level;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      samples <= {3{`ICU_NMI_PIN_RST}};
      level   <= `ICU_NMI_PIN_RST;
      level_d <= `ICU_NMI_PIN_RST;
    end else begin
      if (sample_en_in) begin
        samples <= {samples[1:0], pin_in};
      end
      level   <= next_level;
      level_d <= level;
    end
  end

  // only the software-chosen edge produces a request
  assign edge_out = rise_sel_in ? (level & ~level_d) : (~level & level_d);

  chk_edge_polarity: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    edge_out |-> (level == rise_sel_in) && ($past(level) != rise_sel_in))
    else $error("pin request on the wrong edge");

  chk_filter_hold: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (filt_en_in && samples != 3'b111 && samples != 3'b000) |=> $stable(level))
    else $error("filtered level moved without three equal samples");
endmodule
`default_nettype wire

// ===== bench/icu_cpu_model.sv
// cpu-side acceptor of the interrupt unit: takes the shown vector after a random wait
// assumes one clock shared with the unit and a registered request level
`timescale 1ns/100ps
`default_nettype none
module icu_cpu_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       en_in,
  input  wire logic       irq_in,
  input  wire logic [7:0] vec_in,
  output logic            ack_out,
  output logic      [7:0] ack_vec_out
);
  int seed = 32'hF960;
  int hold;
  ////////////////////////////////////////
  // after an ack wait two cycles, so the cleared request has reached the outputs;
  // the vector lines wander while idle, so nothing may lean on a stale value
  always @(posedge clk_in) begin
    ack_vec_out <= ack_vec_out + 8'h5B;
    if (rst_in || !en_in || ack_out) begin
      ack_out <= 1'b0;
      hold    <= 2;
    end else if (hold != 0) begin
      hold <= hold - 1;
    end else if (irq_in && ($random(seed) & 1)) begin
      ack_out     <= 1'b1;
      ack_vec_out <= vec_in;
    end
  end
endmodule
`default_nettype wire

// ===== bench/interrupt_priority_nmi_unit_bench.sv
// self-checking bench of the interrupt unit, with a queue model of the pending cpu requests
// assumes icu_core, its package and register header, and the cpu acceptor model
`timescale 1ns/100ps
`default_nettype none
`include "icu_regs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module interrupt_priority_nmi_unit_bench import icu_pkg::*;;
  logic         clk, rst, wr, rd, ack, irq, firq, x0, x1, nmi, ack_en;
  logic [9:0]   addr;
  logic [31:0]  wdata, rdata;
  logic [255:0] preq, xack, data_transfer_controller, dma;
  logic [7:0]   ackv, vec, fvec;
  logic [3:0]   lvl;
  logic [6:0]   ev;
  int           num_errors, compares, seed, cyc, n0, n1, w;
  int           lv[256];
  int           pend[$];
  int           ix[3] = '{27, 28, 0};
  int           xs[4] = '{144, 208, 145, 209};
  ////////////////////////////////////////
  // source 0x80 is the one level source, every other source is edge detected
  icu_core #(.N_SRC(256), .EDGE_MASK(~(256'h1 << 8'h80))) icu_core_i (
    .core_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .periph_req_in(preq),
    .cpu_ack_in(ack), .cpu_ack_vec_in(ackv), .xfer_ack_in(xack), .cpu_irq_out(irq),
    .cpu_vec_out(vec), .cpu_level_out(lvl), .cpu_fast_irq_out(firq),
    .cpu_fast_vec_out(fvec), .data_transfer_controller_req_out(data_transfer_controller),
    .dma_controller_req_out(dma), .external_bus_dma_ch0_start_out(x0),
    .external_bus_dma_ch1_start_out(x1), .nmi_pin_in(ev[0]), .osc_stop_in(ev[1]),
    .system_watchdog_err_in(ev[2]), .independent_watchdog_err_in(ev[3]),
    .voltage_detector_one_in(ev[4]), .voltage_detector_two_in(ev[5]),
    .ram_parity_err_in(ev[6]), .nmi_irq_out(nmi));
  icu_cpu_model icu_cpu_model_i (.clk_in(clk), .rst_in(rst), .en_in(ack_en),
    .irq_in(irq), .vec_in(vec), .ack_out(ack), .ack_vec_out(ackv));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////
  // model winner: highest level, the lower index on a tie
  function automatic int win();
    int b = -1;
    foreach (pend[k])
      if (b < 0 || lv[pend[k]] > lv[b] || (lv[pend[k]] == lv[b] && pend[k] < b)) b = pend[k];
    return b;
  endfunction
  task automatic test_done();
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, d)
  endtask
  task automatic set_in(input int s, input int i, input logic v);
    @(posedge clk);
    case (s)
      0: preq[i] <= v;
      1: xack[i] <= v;
      default: ev[i] <= v;
    endcase
  endtask
  // one-cycle pulse, then room for the two-cycle path to the outputs
  task automatic strobe(input int s, input int i);
    set_in(s, i, 1'b1);
    set_in(s, i, 1'b0);
    repeat (3) @(negedge clk);
  endtask
  ////////////////////////////////////////
  // acks are checked against the model and retire its entry; hangs are cut short
  always @(posedge clk) begin
    cyc++;
    n0 += (x0 === 1'b1);
    n1 += (x1 === 1'b1);
    if (ack === 1'b1) begin
      w = win();
      `CHK(ackv, 8'(w))
      for (int k = 0; k < pend.size(); k++) if (pend[k] == w) pend.delete(k);
    end
    // the ceiling lies far above the few hundred cycles the scenarios need
    if (cyc == 4000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    seed = 32'hF960;
    {rst, wr, rd, ack_en, addr, wdata} = {4'h8, 42'h0};
    {preq, xack, ev} = {512'h0, 7'h01};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`ICU_OFS_SRC_CFG + 10'h005, 32'h40);
    rd_chk(`ICU_OFS_NMI_EN, 32'h0);
    rd_chk(10'h3FF, 32'h0);
    // masked flag still latches, the merged request stays low
    strobe(2, 1);
    rd_chk(`ICU_OFS_NMI_STAT, 32'h2);
    `CHK(nmi, 1'b0)
    wr_reg(`ICU_OFS_NMI_STAT, 32'h2);
    wr_reg(`ICU_OFS_NMI_EN, 32'h7F);
    for (int k = 1; k < ICU_NMI_N; k++) begin
      strobe(2, k);
      `CHK(nmi, 1'b1)
      rd_chk(`ICU_OFS_NMI_STAT, 32'h1 << k);
      wr_reg(`ICU_OFS_NMI_STAT, 32'h1 << k);
      rd_chk(`ICU_OFS_NMI_STAT, 32'h0);
      `CHK(nmi, 1'b0)
    end
    // pin: rising selected with filter off, then falling with a one-sample glitch filtered
    wr_reg(`ICU_OFS_NMI_CTRL, 32'h1);
    set_in(2, 0, 1'b0);
    rd_chk(`ICU_OFS_NMI_STAT, 32'h0);
    set_in(2, 0, 1'b1);
    repeat (3) @(negedge clk);
    rd_chk(`ICU_OFS_NMI_STAT, 32'h1);
    wr_reg(`ICU_OFS_NMI_STAT, 32'h1);
    wr_reg(`ICU_OFS_NMI_CTRL, 32'h2);
    set_in(2, 0, 1'b0);
    set_in(2, 0, 1'b1);
    repeat (6) @(negedge clk);
    rd_chk(`ICU_OFS_NMI_STAT, 32'h0);
    set_in(2, 0, 1'b0);
    repeat (6) @(negedge clk);
    rd_chk(`ICU_OFS_NMI_STAT, 32'h1);
    // slow sampling: a rise needs three samples eight cycles apart
    wr_reg(`ICU_OFS_NMI_STAT, 32'h1);
    wr_reg(`ICU_OFS_NMI_CTRL, 32'h7);
    set_in(2, 0, 1'b1);
    repeat (8) @(negedge clk);
    rd_chk(`ICU_OFS_NMI_STAT, 32'h0);
    repeat (24) @(negedge clk);
    rd_chk(`ICU_OFS_NMI_STAT, 32'h1);
    `CHK(nmi, 1'b1)
    // both software sources race one random peripheral at random levels
    for (int r = 0; r < 3; r++) begin
      ix[2] = 32 + {$random(seed)} % 64;
      foreach (ix[j]) begin
        lv[ix[j]] = 1 + {$random(seed)} % 15;
        wr_reg(`ICU_OFS_SRC_CFG + 10'(ix[j]), 32'h40 | lv[ix[j]]);
        pend.push_back(ix[j]);
      end
      wr_reg(`ICU_OFS_SWINT_TRIG, 32'h3);
      strobe(0, ix[2]);
      `CHK(irq, 1'b1)
      `CHK(vec, 8'(win()))
      `CHK(lvl, 4'(lv[win()]))
      ack_en = 1'b1;
      for (int t = 0; t < 60 && pend.size() > 0; t++) @(negedge clk);
      repeat (3) @(negedge clk);
      `CHK(irq, 1'b0)
      `CHK(pend.size(), 0)
      ack_en = 1'b0;
    end
    // level source follows its input and needs no ack
    wr_reg(`ICU_OFS_SRC_CFG + 10'h080, 32'h46);
    set_in(0, 128, 1'b1);
    repeat (3) @(negedge clk);
    `CHK({irq, vec}, 9'h180)
    set_in(0, 128, 1'b0);
    repeat (3) @(negedge clk);
    `CHK(irq, 1'b0)
    // fast source bypasses normal arbitration, so the normal request stays low
    wr_reg(`ICU_OFS_SRC_CFG + 10'h040, 32'h49);
    wr_reg(`ICU_OFS_FAST_SEL, 32'h140);
    strobe(0, 64);
    `CHK({firq, fvec, irq}, 10'h280)
    strobe(1, 64);
    `CHK(firq, 1'b0)
    // transfer routing: dtc alone, then dma beside the cpu
    for (int m = 0; m < 2; m++) begin
      wr_reg(`ICU_OFS_SRC_CFG + 10'(80 + m), 32'h11 | (m << 5) | (m << 6));
      strobe(0, 80 + m);
      `CHK({data_transfer_controller[80 + m], dma[80 + m], irq}, {1'(1 - m), 1'(m), 1'(m)})
      strobe(1, 80 + m);
      `CHK({data_transfer_controller[80 + m], dma[80 + m], irq}, 3'h0)
    end
    // each external dma source gives exactly one start pulse on its own channel
    wr_reg(`ICU_OFS_EXDMA_CTRL, 32'h3);
    foreach (xs[j]) begin
      n0 = 0;
      n1 = 0;
      strobe(0, xs[j]);
      repeat (2) @(negedge clk);
      `CHK({n0, n1}, {32'(j < 2), 32'(j >= 2)})
    end
    test_done();
  end
endmodule
`default_nettype wire
